//--- hw/accel_map.svh
// register offsets, frame layout and field positions of the acceleration output words
`ifndef ACCEL_MAP_SVH
`define ACCEL_MAP_SVH

`define ACC_X_LOW_OFS    7'h10
`define ACC_X_MAIN_OFS   7'h12
`define ACC_Y_LOW_OFS    7'h14
`define ACC_Y_MAIN_OFS   7'h16
`define ACC_Z_LOW_OFS    7'h18
`define ACC_Z_MAIN_OFS   7'h1a

`define ACC_WORD_W       16
`define ACC_FULL_W       32
`define ACC_MAIN_MSB     31
`define ACC_MAIN_LSB     16
`define ACC_LOW_MSB      15
`define ACC_LOW_LSB      0

`define ACC_FRAME_BITS   5'h10
`define ACC_CNT_W        5
`define ACC_RW_BIT       15
`define ACC_ADDR_MSB     14
`define ACC_ADDR_LSB     8
`define ACC_ADDR_W       7
`define ACC_TX_MSB       15

`define ACC_WORD_ZERO    16'h0000
`define ACC_FULL_ZERO    32'h0000_0000
`define ACC_CNT_ZERO     5'h00
`define ACC_CNT_ONE      5'h01

`endif

//--- hw/accel_pkg.sv
// types shared by the acceleration output register block
package accel_pkg;

  // one axis as delivered by the filter path: full signed result
  typedef logic signed [31:0] accel_full_t;

  typedef struct packed {
    accel_full_t x;
    accel_full_t y;
    accel_full_t z;
  } accel_sample_t;

  // one axis as stored: primary (upper) and secondary (lower) word
  typedef struct packed {
    logic [15:0] main_word;
    logic [15:0] low_word;
  } accel_axis_t;

  typedef struct packed {
    accel_axis_t x;
    accel_axis_t y;
    accel_axis_t z;
  } accel_bank_t;

  // serial pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic cs_b;
    logic mosi;
  } serial_pins_t;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_SHIFT,
    SER_END
  } serial_state_t;

endpackage : accel_pkg

//--- hw/accel_sample_bank.sv
// holding registers for the three axes, loaded together from the filter path
`timescale 1ns/10ps
`include "accel_map.svh"

module accel_sample_bank (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_b_i,
  // filter path, same clock
  input  wire accel_pkg::accel_sample_t sample_i,
  input  wire logic                    sample_valid_i,
  // stored words
  output      accel_pkg::accel_bank_t  bank_o,
  output      logic                    updated_o
);
  import accel_pkg::*;

  accel_bank_t bank_reg;
  accel_bank_t bank_next;
  logic        updated_reg;
  logic        updated_next;

  // upper half is the primary word, lower half the extra filter resolution
  function automatic accel_axis_t split_axis(input accel_full_t full);
    accel_axis_t a;
    a.main_word = full[`ACC_MAIN_MSB:`ACC_MAIN_LSB];
    a.low_word  = full[`ACC_LOW_MSB:`ACC_LOW_LSB];
    return a;
  endfunction : split_axis

  always_comb begin
    bank_next    = bank_reg;
    updated_next = 1'b0;
    if (sample_valid_i) begin
      // all six words move in one edge so no pair is ever torn
      bank_next.x  = split_axis(sample_i.x);
      bank_next.y  = split_axis(sample_i.y);
      bank_next.z  = split_axis(sample_i.z);
      updated_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bank_reg    <= '0;
      updated_reg <= 1'b0;
    end else begin
      bank_reg    <= bank_next;
      updated_reg <= updated_next;
    end
  end

  assign bank_o    = bank_reg;
  assign updated_o = updated_reg;

endmodule : accel_sample_bank

//--- hw/accel_output_regs.sv
// acceleration output registers read over a 16-bit serial register interface
`timescale 1ns/10ps
`include "accel_map.svh"

module accel_output_regs (
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_b_i,
  // filter path, same clock
  input  wire accel_pkg::accel_sample_t sample_i,
  input  wire logic                     sample_valid_i,
  // serial register pins
  input  wire logic                     sclk_i,
  input  wire logic                     cs_b_i,
  input  wire logic                     mosi_i,
  output      logic                     miso_o,
  output      logic                     miso_oe_o,
  // status
  output      logic                     data_ready_o
);
  import accel_pkg::*;

  // pin synchronisers
  serial_pins_t  pins_meta_reg;
  serial_pins_t  pins_sync_reg;
  serial_pins_t  pins_last_reg;

  // frame engine
  serial_state_t state_reg;
  serial_state_t state_next;
  logic [`ACC_CNT_W-1:0]  bit_cnt_reg;
  logic [`ACC_CNT_W-1:0]  bit_cnt_next;
  logic [`ACC_WORD_W-1:0] rx_reg;
  logic [`ACC_WORD_W-1:0] rx_next;
  logic [`ACC_WORD_W-1:0] tx_reg;
  logic [`ACC_WORD_W-1:0] tx_next;
  logic [`ACC_WORD_W-1:0] resp_reg;
  logic [`ACC_WORD_W-1:0] resp_next;
  logic                   miso_reg;
  logic                   miso_next;
  logic                   oe_reg;
  logic                   oe_next;
  logic                   ready_reg;

  // edges of the synchronised pins
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   cs_fall;
  logic                   cs_rise;

  accel_bank_t            bank;
  logic                   bank_updated;

  accel_sample_bank u_bank (
    .mclk_i         (mclk_i),
    .rst_b_i        (rst_b_i),
    .sample_i       (sample_i),
    .sample_valid_i (sample_valid_i),
    .bank_o         (bank),
    .updated_o      (bank_updated)
  );

  // word address decode; unmapped offsets read as zero
  function automatic logic [`ACC_WORD_W-1:0] read_word(input logic [`ACC_ADDR_W-1:0] addr,
                                                       input accel_bank_t b);
    logic [`ACC_ADDR_W-1:0] word_addr;
    word_addr = {addr[`ACC_ADDR_W-1:1], 1'b0};
    case (word_addr)
      `ACC_X_LOW_OFS:  read_word = b.x.low_word;
      `ACC_X_MAIN_OFS: read_word = b.x.main_word;
      `ACC_Y_LOW_OFS:  read_word = b.y.low_word;
      `ACC_Y_MAIN_OFS: read_word = b.y.main_word;
      `ACC_Z_LOW_OFS:  read_word = b.z.low_word;
      `ACC_Z_MAIN_OFS: read_word = b.z.main_word;
      default:         read_word = `ACC_WORD_ZERO;
    endcase
  endfunction : read_word

  // two stages before any logic; the third copy only feeds edge detection
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_meta_reg <= '{sclk: 1'b1, cs_b: 1'b1, mosi: 1'b0};
      pins_sync_reg <= '{sclk: 1'b1, cs_b: 1'b1, mosi: 1'b0};
      pins_last_reg <= '{sclk: 1'b1, cs_b: 1'b1, mosi: 1'b0};
    end else begin
      pins_meta_reg <= '{sclk: sclk_i, cs_b: cs_b_i, mosi: mosi_i};
      pins_sync_reg <= pins_meta_reg;
      pins_last_reg <= pins_sync_reg;
    end
  end

  assign sclk_rise = pins_sync_reg.sclk & ~pins_last_reg.sclk;
  assign sclk_fall = ~pins_sync_reg.sclk & pins_last_reg.sclk;
  assign cs_fall   = ~pins_sync_reg.cs_b & pins_last_reg.cs_b;
  assign cs_rise   = pins_sync_reg.cs_b & ~pins_last_reg.cs_b;

  // clock-idle-high framing: sample on rising, shift out on falling.
  // the answer to a read comes in the next frame, so no fast turnaround is needed;
  // sclk must stay below a quarter of mclk because of the synchronisers.
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    resp_next    = resp_reg;
    miso_next    = miso_reg;
    oe_next      = oe_reg;
    case (state_reg)
      SER_IDLE: begin
        oe_next   = 1'b0;
        miso_next = 1'b0;
        if (cs_fall) begin
          state_next   = SER_SHIFT;
          bit_cnt_next = `ACC_CNT_ZERO;
          tx_next      = resp_reg;
          miso_next    = resp_reg[`ACC_TX_MSB];
          oe_next      = 1'b1;
        end
      end
      SER_SHIFT: begin
        if (cs_rise) begin
          state_next = SER_END;
        end else begin
          if (sclk_rise) begin
            rx_next      = {rx_reg[`ACC_WORD_W-2:0], pins_sync_reg.mosi};
            bit_cnt_next = bit_cnt_reg + `ACC_CNT_ONE;
          end
          if (sclk_fall && bit_cnt_reg != `ACC_CNT_ZERO) begin
            tx_next   = {tx_reg[`ACC_WORD_W-2:0], 1'b0};
            miso_next = tx_reg[`ACC_TX_MSB-1];
          end
        end
      end
      SER_END: begin
        state_next = SER_IDLE;
        oe_next    = 1'b0;
        // released line rests low, never on the last shifted bit
        miso_next  = 1'b0;
        // a frame whose bit count modulo 32 is not 16 is dropped and the pending answer is kept
        if (bit_cnt_reg == `ACC_FRAME_BITS) begin
          if (rx_reg[`ACC_RW_BIT]) begin
            // all words here are read only: nothing is stored
            resp_next = `ACC_WORD_ZERO;
          end else begin
            resp_next = read_word(rx_reg[`ACC_ADDR_MSB:`ACC_ADDR_LSB], bank);
          end
        end
      end
      default: begin
        state_next = SER_IDLE;
        oe_next    = 1'b0;
        miso_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg   <= SER_IDLE;
      bit_cnt_reg <= `ACC_CNT_ZERO;
      rx_reg      <= `ACC_WORD_ZERO;
      tx_reg      <= `ACC_WORD_ZERO;
      resp_reg    <= `ACC_WORD_ZERO;
      miso_reg    <= 1'b0;
      oe_reg      <= 1'b0;
      ready_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      resp_reg    <= resp_next;
      miso_reg    <= miso_next;
      oe_reg      <= oe_next;
      ready_reg   <= bank_updated;
    end
  end

  assign miso_o       = miso_reg;
  assign miso_oe_o    = oe_reg;
  assign data_ready_o = ready_reg;

endmodule : accel_output_regs

//--- bench/accel_output_regs_props.sv
// concurrent checks on the acceleration output register pins
`timescale 1ns/10ps
module accel_output_regs_props (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // pins
  input wire logic sample_valid_i,
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic data_ready_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_ready_two;
    ##2 data_ready_o;
  endsequence
  sequence s_cs_low;
    !cs_b_i [*8];
  endsequence
  AST_READY_LAG: assert property (sample_valid_i |-> s_ready_two) else $error("ready late");
  AST_READY_CAUSE: assert property (data_ready_o |-> $past(sample_valid_i, 2)) else $error("ready unasked");
  AST_MISO_QUIET: assert property (!miso_oe_o |-> !miso_o) else $error("miso not quiet");
  AST_OE_IDLE: assert property (cs_b_i [*8] |-> !miso_oe_o) else $error("oe stuck");
  AST_OE_RISE: assert property ($fell(cs_b_i) |-> ##[1:5] miso_oe_o) else $error("oe late");
  AST_OE_CAUSE: assert property ($rose(miso_oe_o) |-> !$past(cs_b_i, 2)) else $error("oe unasked");
  AST_OE_SPAN: assert property (s_cs_low |-> miso_oe_o) else $error("oe dropped");
  // a late sample must not disturb the bit being shifted
  AST_MISO_STILL: assert property (miso_oe_o && $past(miso_oe_o) && $changed(miso_o) |-> !sclk_i)
    else $error("miso moved");
endmodule : accel_output_regs_props

//--- bench/accel_host_model.sv
// serial host model: one 16-bit frame per call, sclk idles high
`timescale 1ns/10ps
module accel_host_model (
  // clock
  input  wire logic mclk_i,
  // serial pins
  input  wire logic miso_i,
  output      logic sclk_o,
  output      logic cs_b_o,
  output      logic mosi_o
);
  initial begin
    sclk_o = 1'b1;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    cs_b_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= tx[i];
      sclk_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      rx[i] = miso_i;
      repeat (4) @(posedge mclk_i);
    end
    cs_b_o <= 1'b1;
    // released line must not keep the last bit
    mosi_o <= ~tx[0];
    repeat (6) @(posedge mclk_i);
  endtask : frame
endmodule : accel_host_model

//--- bench/accel_output_regs_tb_top.sv
// self-checking bench for the acceleration output registers
`timescale 1ns/10ps
module accel_output_regs_tb_top;
  import accel_pkg::*;
  logic          mclk_i, rst_b_i, sample_valid_i, sclk_i, cs_b_i, mosi_i, miso_o, miso_oe_o, data_ready_o;
  accel_sample_t sample_i;
  logic [15:0]   rx;
  logic [15:0]   got [6];
  int            mismatches = 0;
  int            comparisons = 0;

  accel_output_regs i_accel_output_regs (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i), .mosi_i(mosi_i),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .data_ready_o(data_ready_o));
  accel_host_model i_accel_host_model (.mclk_i(mclk_i), .miso_i(miso_o), .sclk_o(sclk_i),
    .cs_b_o(cs_b_i), .mosi_o(mosi_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [6:0] a);
    i_accel_host_model.frame({1'b0, a, 8'h00}, rx);
  endtask : rd
  task automatic load(input accel_sample_t s);
    sample_i <= s;
    sample_valid_i <= 1'b1;
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
    @(negedge mclk_i);
    check(data_ready_o, 1'b0);
    check(miso_oe_o, 1'b0);
    @(negedge mclk_i);
    check(data_ready_o, 1'b1);
    @(negedge mclk_i);
    check(data_ready_o, 1'b0);
    @(posedge mclk_i);
  endtask : load
  // all six words through the pipelined reads, then an unmapped place
  task automatic scn_map;
    load('{x: 32'h4e20_0000, y: 32'hffff_c000, z: 32'h0000_4000});
    rd(7'h10);
    for (int i = 1; i <= 6; i++) begin
      rd(i < 6 ? 7'h10 + 7'(2 * i) : 7'h1c);
      got[i - 1] = rx;
    end
    rd(7'h00);
    check(rx, 32'h0);
    check({got[1], got[0]}, 32'h4e20_0000);
    check({got[3], got[2]}, 32'hffff_c000);
    check({got[5], got[4]}, 32'h0000_4000);
    // 18-bit host result: 0.0625 mg per count
    check({got[1], got[0][15:14]}, 18'h13880);
    check({got[3], got[2][15:14]}, 18'h3ffff);
    check({got[5], got[4][15:14]}, 18'h00001);
  endtask : scn_map
  // write to a primary word: answer zero, word unchanged
  task automatic scn_write;
    i_accel_host_model.frame(16'h92ab, rx);
    rd(7'h12);
    check(rx, 32'h0);
    rd(7'h12);
    check(rx, 32'h4e20);
  endtask : scn_write
  // new sample with the most negative primary word
  task automatic scn_update;
    load('{x: 32'h0000_0000, y: 32'h7fff_ffff, z: 32'h8000_0001});
    rd(7'h1a);
    check(rx, 32'h4e20);
    rd(7'h18);
    check(rx, 32'h8000);
    rd(7'h16);
    check(rx, 32'h0001);
    rd(7'h12);
    check(rx, 32'h7fff);
    rd(7'h00);
    check(rx, 32'h0000);
  endtask : scn_update
  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    finish_test();
  end
  initial begin
    rst_b_i = 1'b0;
    sample_valid_i = 1'b0;
    sample_i = '0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    scn_map();
    scn_write();
    scn_update();
    finish_test();
  end
endmodule : accel_output_regs_tb_top

bind accel_output_regs accel_output_regs_props i_accel_output_regs_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .sample_valid_i(sample_valid_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .data_ready_o(data_ready_o));
